//--- rbc_pkg.sv
// Shared constants, register map and state codes of the reset and boot pin control block
package rbc_pkg;

	// Register byte offsets on the APB
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_STATUS = 12'h004;
	localparam logic [11:0] OFS_INT_STAT = 12'h008;
	localparam logic [11:0] OFS_INT_MASK = 12'h00c;

	// Control register fields
	localparam int CTRL_BIDIR = 0;

	// Status register fields
	localparam int ST_CAUSE_HW = 0;
	localparam int ST_HW_LONG = 1;
	localparam int ST_CAUSE_SW = 2;
	localparam int ST_CAUSE_WDT = 3;
	localparam int ST_INIT_DONE = 4;
	localparam int ST_BOOT_EXT = 5;
	localparam int ST_BOOT_LDR = 6;
	localparam int ST_OSC_WDT = 7;
	localparam int ST_PWR_DOWN = 8;
	localparam int ST_NMI_LEVEL = 9;
	localparam int ST_W = 10;

	// Interrupt status and mask fields
	localparam int INT_NMI = 0;
	localparam int INT_RST_DONE = 1;
	localparam int INT_PD_ENTER = 2;
	localparam int INT_PD_REFUSE = 3;
	localparam int INT_W = 4;

	// Boot loader select bit within the low byte of the bus port
	localparam int BOOT_LDR_BIT = 4;

	// Reset values
	localparam logic CTRL_BIDIR_RST = 1'b0;
	localparam logic [INT_W-1:0] INT_MASK_RST = 4'h0;
	localparam logic [INT_W-1:0] INT_STAT_RST = 4'h0;
	localparam logic RST_IND_RST = 1'b0;
	localparam logic NMI_IDLE_RST = 1'b1;

	// Timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int MIN_RST_NS = 100;
	localparam int MIN_RST_CYC = (MIN_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int GUARD_CYC = 3;
	localparam int SEQ_CYCLES_DEF = 1024;

	// Reset sequencer states
	typedef enum logic [3:0] {
		SQ_RUN = 4'b0001,
		SQ_HOLD = 4'b0010,
		SQ_SEQ = 4'b0100,
		SQ_GUARD = 4'b1000
	} rbc_seq_state_t;

endpackage

//--- rbc_seq_if.sv
// Signals between the top level and the reset sequencer
`timescale 1ns/1ns
`default_nettype none
interface rbc_seq_if;
	logic pin_low;
	logic sw_req;
	logic wdt_req;
	logic bidir_en;
	logic start;
	logic done;
	logic in_reset;
	logic pull_pin;
	logic bidir_act;
	logic cause_hw;
	logic hw_long;
	logic cause_sw;
	logic cause_wdt;

	modport seq (
		input pin_low, sw_req, wdt_req, bidir_en,
		output start, done, in_reset, pull_pin, bidir_act,
		output cause_hw, hw_long, cause_sw, cause_wdt
	);
	modport top (
		output pin_low, sw_req, wdt_req, bidir_en,
		input start, done, in_reset, pull_pin, bidir_act,
		input cause_hw, hw_long, cause_sw, cause_wdt
	);
endinterface
`default_nettype wire

//--- rbc_sync.sv
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ns
`default_nettype none
module rbc_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Asynchronous pins and their synchronised copy
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;
	logic [W-1:0] q_r;

	// First stage feeds only the second stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= RST_VAL;
			q_r <= RST_VAL;
		end else begin
			meta_r <= d;
			q_r <= meta_r;
		end
	end

	assign q = q_r;
endmodule
`default_nettype wire

//--- rbc_seq.sv
// Internal reset sequencer: cause capture, pin pull and stretching
`timescale 1ns/1ns
`default_nettype none
module rbc_seq import rbc_pkg::*; #(
	parameter int SEQ_CYCLES = SEQ_CYCLES_DEF
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Link to the top level
	rbc_seq_if.seq sq
);
	localparam int CW = $clog2(SEQ_CYCLES + 1);
	localparam logic [CW-1:0] SEQ_LAST = CW'(SEQ_CYCLES - 1);
	localparam logic [CW-1:0] SEQ_FULL = CW'(SEQ_CYCLES);
	localparam logic [CW-1:0] MIN_LAST = CW'(MIN_RST_CYC - 1);
	localparam logic [CW-1:0] GUARD_LAST = CW'(GUARD_CYC - 1);

	rbc_seq_state_t state_r, state_nxt;
	logic [CW-1:0] cnt_r, cnt_nxt;
	logic start_nxt, done_nxt;
	logic start_r, done_r, in_reset_r, pull_r, bidir_act_r;
	logic cause_hw_r, hw_long_r, cause_sw_r, cause_wdt_r;
	wire hw_req;
	wire [CW-1:0] cnt_sat;
	wire act_now;

	// Pin must be seen low for the least recognition time
	assign hw_req = sq.pin_low && (cnt_r >= MIN_LAST); // [R01] [R02]
	assign cnt_sat = (cnt_r == SEQ_FULL) ? cnt_r : cnt_r + 1'b1;
	// Mode of the reset now starting, or of the one running
	assign act_now = start_nxt ? sq.bidir_en : bidir_act_r;

	// Next state; pin level is ignored while we pull it ourselves
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		start_nxt = 1'b0;
		done_nxt = 1'b0;
		case (state_r)
			SQ_RUN: begin
				cnt_nxt = sq.pin_low ? cnt_sat : '0;
				if (hw_req) begin
					start_nxt = 1'b1;
					state_nxt = sq.bidir_en ? SQ_SEQ : SQ_HOLD; // [R12]
					if (sq.bidir_en) begin
						cnt_nxt = '0;
					end
				end else if (sq.sw_req || sq.wdt_req) begin
					start_nxt = 1'b1;
					state_nxt = SQ_SEQ;
					cnt_nxt = '0;
				end
			end
			SQ_HOLD: begin
				if (sq.pin_low) begin
					cnt_nxt = cnt_sat; // [R01]
				end else begin
					done_nxt = 1'b1;
					state_nxt = SQ_RUN;
					cnt_nxt = '0;
				end
			end
			SQ_SEQ: begin
				cnt_nxt = cnt_r + 1'b1;
				if (cnt_r == SEQ_LAST) begin // [R15]
					cnt_nxt = '0;
					if (bidir_act_r) begin
						state_nxt = SQ_GUARD;
					end else begin
						done_nxt = 1'b1;
						state_nxt = SQ_RUN;
					end
				end
			end
			SQ_GUARD: begin
				// Wait out synchroniser latency after releasing the line
				cnt_nxt = cnt_r + 1'b1;
				if (cnt_r == GUARD_LAST) begin
					cnt_nxt = '0;
					if (sq.pin_low) begin
						state_nxt = SQ_HOLD;
					end else begin
						done_nxt = 1'b1;
						state_nxt = SQ_RUN;
					end
				end
			end
			default: begin
				state_nxt = SQ_RUN;
				cnt_nxt = '0;
			end
		endcase
	end

	// Power-on acts as a long hardware reset with a full sequence
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= SQ_SEQ;
			cnt_r <= '0;
			start_r <= 1'b0;
			done_r <= 1'b0;
			in_reset_r <= 1'b1;
			pull_r <= 1'b0;
			bidir_act_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			start_r <= start_nxt;
			done_r <= done_nxt;
			in_reset_r <= (state_nxt != SQ_RUN);
			pull_r <= (state_nxt == SQ_SEQ) && act_now; // [R03] [R15]
			bidir_act_r <= act_now;
		end
	end

	// Cause flags; bidirectional mode always reports a long hardware reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cause_hw_r <= 1'b1;
			hw_long_r <= 1'b1;
			cause_sw_r <= 1'b0;
			cause_wdt_r <= 1'b0;
		end else if (start_nxt) begin
			cause_hw_r <= hw_req || sq.bidir_en; // [R10]
			hw_long_r <= sq.bidir_en; // [R10]
			cause_sw_r <= !sq.bidir_en && !hw_req && sq.sw_req;
			cause_wdt_r <= !sq.bidir_en && !hw_req && !sq.sw_req && sq.wdt_req;
		end else if (state_r == SQ_HOLD && !sq.pin_low && !bidir_act_r) begin
			hw_long_r <= (cnt_r >= SEQ_LAST);
		end
	end

	assign sq.start = start_r;
	assign sq.done = done_r;
	assign sq.in_reset = in_reset_r;
	assign sq.pull_pin = pull_r;
	assign sq.bidir_act = bidir_act_r;
	assign sq.cause_hw = cause_hw_r;
	assign sq.hw_long = hw_long_r;
	assign sq.cause_sw = cause_sw_r;
	assign sq.cause_wdt = cause_wdt_r;
endmodule
`default_nettype wire

//--- rbc_top.sv
// Reset and boot pin control: reset pin, indication, NMI, boot strap sampling, APB registers
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// [R01] A reset request pin held low while the oscillator runs puts the device into reset.
// [R02] The outside source holds the request low at least 100 ns plus two clock periods.
// [R03] In bidirectional mode the device pulls the request line low for the whole sequence.
// [R04] The reset indication output is low from any reset until end of init executes.
// [R05] A falling edge on the NMI input raises a trap to the CPU.
// [R06] Power-down is entered only if NMI is low when the instruction runs, else nothing; a refused request here sets the refusal interrupt flag.
// [R07] External-access select low at reset boots externally, high boots internally.
// [R08] The oscillator watchdog is on while its enable pin is high or open, off when low.
// [R09] The bidirectional enable is writable only before end of init and cleared by reset.
// [R10] In bidirectional mode the cause flags always report a long hardware reset.
// [R11] In bidirectional mode the bus port strap is sampled and bit 4 low starts the loader.
// [R12] In bidirectional mode a short hardware request is stretched to the full sequence.
// [R13] Outside drivers of the request line must be open drain in bidirectional mode.
// [R14] The outside source should hold reset about 1 ms for strap settling and clock lock.
// [R15] The sequence length is one parameter shared by line pulling and stretching.
module rbc_top import rbc_pkg::*; #(
	parameter int SEQ_CYCLES = SEQ_CYCLES_DEF,
	parameter int AW = 12
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Reset request pin, open drain
	input wire logic reset_request_pin_i,
	output logic reset_request_pin_o,
	output logic reset_request_pin_oe,
	output logic reset_indication_out,
	// Strap and interrupt pins
	input wire logic nmi_pin_i,
	input wire logic external_access_select_i,
	input wire logic osc_watchdog_enable_pin_i,
	input wire logic [7:0] multiplexed_bus_port_low_i,
	// CPU side requests
	input wire logic oscillator_running,
	input wire logic end_of_init_instruction,
	input wire logic power_down_instruction,
	input wire logic sw_reset_req,
	input wire logic wdt_reset_req,
	// CPU side results
	output logic core_reset_n,
	output logic nmi_trap,
	output logic power_down_mode,
	output logic boot_from_external,
	output logic boot_loader_active,
	output logic osc_watchdog_en,
	output logic irq
);
	localparam int SW = 12;
	localparam logic [SW-1:0] SYNC_RST = 12'hf00;

	// Decode an address into a one-hot register select
	function automatic logic [3:0] reg_sel(input logic [AW-1:0] a);
		logic [3:0] s;
		s = 4'h0;
		if (a[1:0] == 2'b00) begin
			s[0] = (a == AW'(OFS_CTRL));
			s[1] = (a == AW'(OFS_STATUS));
			s[2] = (a == AW'(OFS_INT_STAT));
			s[3] = (a == AW'(OFS_INT_MASK));
		end
		return s;
	endfunction

	rbc_seq_if sq ();

	// Pin synchronisation
	wire [SW-1:0] sync_q;
	wire rst_s;
	wire nmi_s;
	wire ea_s;
	wire owe_s;
	wire [7:0] port_s;

	// Idle levels: pull-ups hold request, NMI, select and enable high
	// A pin pulse shorter than two clocks may be missed, hence the minimum hold
	rbc_sync #(
		.W(SW),
		.RST_VAL(SYNC_RST)
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d({reset_request_pin_i, nmi_pin_i, external_access_select_i,
			osc_watchdog_enable_pin_i, multiplexed_bus_port_low_i}),
		.q(sync_q)
	);

	assign rst_s = sync_q[11];
	assign nmi_s = sync_q[10];
	assign ea_s = sync_q[9];
	assign owe_s = sync_q[8];
	assign port_s = sync_q[7:0];

	// Reset sequencer
	rbc_seq #(
		.SEQ_CYCLES(SEQ_CYCLES)
	) u_seq (
		.pclk(pclk),
		.presetn(presetn),
		.sq(sq)
	);

	// Request only counts while the oscillator runs
	assign sq.pin_low = !rst_s && oscillator_running; // [R01]
	assign sq.sw_req = sw_reset_req;
	assign sq.wdt_req = wdt_reset_req;

	// Registers
	logic bidir_en_r, init_done_r, rst_ind_r;
	logic core_rst_n_r, pin_oe_r, pin_o_r;
	logic nmi_d_r, nmi_trap_r, pd_r;
	logic boot_ext_r, boot_ldr_r, owe_r, irq_r;
	logic [INT_W-1:0] int_stat_r, int_mask_r;
	logic [31:0] prdata_r;
	logic pready_r, pslverr_r;

	assign sq.bidir_en = bidir_en_r;

	// APB decode; the answer comes one cycle into the access phase
	wire [3:0] sel;
	wire acc;
	wire wr_go;
	wire unmapped;
	assign sel = reg_sel(paddr);
	assign acc = psel && penable && !pready_r;
	assign wr_go = psel && penable && pready_r && pwrite;
	assign unmapped = (sel == 4'h0);

	// Per-register strobes; misaligned addresses select nothing and answer an error
	wire ctrl_wr;
	wire stat_clr_wr;
	wire mask_wr;
	wire rd_go;
	assign ctrl_wr = wr_go && sel[0] && !init_done_r; // [R09]
	assign stat_clr_wr = wr_go && sel[2];
	assign mask_wr = wr_go && sel[3];
	assign rd_go = acc && !pwrite;

	// CPU events, ignored while the core is held in reset
	wire end_of_init_instruction_go;
	wire nmi_fall;
	wire pd_req;
	wire pd_enter;
	wire pd_refuse;
	wire nmi_ev;
	assign end_of_init_instruction_go = end_of_init_instruction && !sq.in_reset;
	assign nmi_fall = nmi_d_r && !nmi_s; // [R05]
	// Taken from the synchronised level, so a trap lags the pin by three clocks
	assign nmi_ev = nmi_fall && !sq.in_reset;
	assign pd_req = power_down_instruction && !sq.in_reset;
	assign pd_enter = pd_req && !nmi_s; // [R06]
	assign pd_refuse = pd_req && nmi_s; // [R06]

	// Interrupt status: set beats a simultaneous write-one clear
	wire [INT_W-1:0] int_ev;
	wire [INT_W-1:0] int_clr;
	assign int_ev = {pd_refuse, pd_enter, sq.done, nmi_ev};
	assign int_clr = stat_clr_wr ? pwdata[INT_W-1:0] : '0;

	// Status word
	// Cause flags come straight from the sequencer and change at a reset start; the long flag also updates when a held pin is released
	wire [ST_W-1:0] status;
	assign status = {nmi_s, pd_r, owe_r, boot_ldr_r, boot_ext_r, init_done_r,
		sq.cause_wdt, sq.cause_sw, sq.hw_long, sq.cause_hw};

	// Read mux; reserved bits read zero
	wire [31:0] rd_mux;
	assign rd_mux = sel[0] ? {31'h0, bidir_en_r} :
		sel[1] ? {22'h0, status} :
		sel[2] ? {28'h0, int_stat_r} :
		sel[3] ? {28'h0, int_mask_r} : 32'h0;

	// Bidirectional enable: locked after end of init, cleared by any reset
	// A reset start beats a write in the same cycle, so the bit always comes up clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bidir_en_r <= CTRL_BIDIR_RST;
		end else if (sq.start) begin
			bidir_en_r <= 1'b0; // [R09]
		end else if (ctrl_wr) begin
			bidir_en_r <= pwdata[CTRL_BIDIR]; // [R09]
		end
	end

	// End of init tracking and the reset indication pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init_done_r <= 1'b0;
			rst_ind_r <= RST_IND_RST;
		end else if (sq.start || sq.in_reset) begin
			init_done_r <= 1'b0;
			rst_ind_r <= 1'b0; // [R04]
		end else if (end_of_init_instruction_go) begin
			init_done_r <= 1'b1;
			rst_ind_r <= 1'b1; // [R04]
		end
	end

	// Core reset and open-drain pull of the request line
	// Both lag the sequencer by one clock, so core reset and the pull start together
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_rst_n_r <= 1'b0;
			pin_oe_r <= 1'b0;
			pin_o_r <= 1'b0;
		end else begin
			core_rst_n_r <= !sq.in_reset; // [R01]
			pin_oe_r <= sq.pull_pin; // [R03]
			pin_o_r <= 1'b0;
		end
	end

	// NMI edge and power-down; only a new reset leaves power-down
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nmi_d_r <= NMI_IDLE_RST;
			nmi_trap_r <= 1'b0;
			pd_r <= 1'b0;
		end else begin
			nmi_d_r <= nmi_s;
			nmi_trap_r <= nmi_ev; // [R05]
			if (sq.start) begin
				pd_r <= 1'b0;
			end else if (pd_enter) begin
				pd_r <= 1'b1; // [R06]
			end
		end
	end

	// Boot straps are taken as the sequence ends, the watchdog enable every clock; software resets skip the loader outside bidirectional mode
	// Straps must be steady two clocks before the sequence ends to be seen
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			boot_ext_r <= 1'b0;
			boot_ldr_r <= 1'b0;
			owe_r <= 1'b1;
		end else begin
			owe_r <= owe_s; // [R08]
			if (sq.done) begin
				boot_ext_r <= !ea_s; // [R07]
				boot_ldr_r <= sq.cause_hw && !port_s[BOOT_LDR_BIT]; // [R11]
			end
		end
	end

	// Interrupt status, mask and output
	// The output is a level one clock behind the status; clearing the bit drops it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_stat_r <= INT_STAT_RST;
			int_mask_r <= INT_MASK_RST;
			irq_r <= 1'b0;
		end else begin
			int_stat_r <= (int_stat_r & ~int_clr) | int_ev;
			if (mask_wr) begin
				int_mask_r <= pwdata[INT_W-1:0];
			end
			irq_r <= |(int_stat_r & int_mask_r);
		end
	end

	// APB answer; error for unmapped or misaligned addresses
	// Exactly one wait state; read data is zero outside the answer cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0;
		end else begin
			pready_r <= acc;
			pslverr_r <= acc && unmapped;
			prdata_r <= rd_go ? rd_mux : 32'h0;
		end
	end

	// Outputs
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	// Pins
	assign reset_request_pin_o = pin_o_r;
	assign reset_request_pin_oe = pin_oe_r;
	assign reset_indication_out = rst_ind_r;
	// CPU side
	assign core_reset_n = core_rst_n_r;
	assign nmi_trap = nmi_trap_r;
	assign power_down_mode = pd_r;
	assign boot_from_external = boot_ext_r;
	assign boot_loader_active = boot_ldr_r;
	assign osc_watchdog_en = owe_r;
	assign irq = irq_r;
endmodule
`default_nettype wire

//--- rbc_sup.sv
// External reset supervisor model: open-drain pull on the reset request line
`timescale 1ns/1ns
`default_nettype none
module rbc_sup import rbc_pkg::*; #(
	parameter int HOLD_MIN = MIN_RST_CYC + 2
) (
	// Clock
	input wire logic pclk,
	// Pulse request and its length in cycles
	input wire logic go,
	input wire logic [7:0] len,
	// Pull towards ground only
	output logic pull
);
	logic [7:0] cnt_r = 8'h00;

	// Never shorter than 100 ns plus two clocks; the long settle is scaled down
	always_ff @(posedge pclk) begin
		if (go) begin
			cnt_r <= (len < 8'(HOLD_MIN)) ? 8'(HOLD_MIN) : len;
		end else if (cnt_r != 8'h00) begin
			cnt_r <= cnt_r - 8'h01;
		end
	end

	// Sinks only, so it never fights the device pulling low
	assign pull = (cnt_r != 8'h00);
endmodule
`default_nettype wire

//--- rbc_assertions.sv
// Concurrent checks on the ports of the reset and boot pin control block
`timescale 1ns/1ns
`default_nettype none
module rbc_assertions #(
	parameter int SEQ_CYCLES = 8
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB handshake
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	// Reset pins
	input wire logic reset_request_pin_i,
	input wire logic reset_request_pin_o,
	input wire logic reset_request_pin_oe,
	input wire logic reset_indication_out,
	// Other pins and CPU side
	input wire logic nmi_pin_i,
	input wire logic osc_watchdog_enable_pin_i,
	input wire logic oscillator_running,
	input wire logic end_of_init_instruction,
	input wire logic power_down_instruction,
	input wire logic core_reset_n,
	input wire logic nmi_trap,
	input wire logic power_down_mode,
	input wire logic osc_watchdog_en
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Cycles of the current pull on the reset line
	int oe_cnt_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oe_cnt_r <= 0;
		end else begin
			oe_cnt_r <= reset_request_pin_oe ? oe_cnt_r + 1 : 0;
		end
	end

	// NMI level held long enough to pass the synchroniser
	sequence nmi_low_s;
		(!nmi_pin_i)[*4];
	endsequence
	sequence nmi_high_s;
		nmi_pin_i[*4];
	endsequence

	apb_wait_a: assert property (psel && penable && !pready |=> pready)
		else $error("apb answer late");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	nmi_trap_a: assert property ($fell(nmi_pin_i) && core_reset_n |-> ##[2:4] nmi_trap)
		else $error("nmi trap missing");
	pd_enter_a: assert property (nmi_low_s ##0 (power_down_instruction && core_reset_n) |=> power_down_mode)
		else $error("power down not entered");
	pd_refuse_a: assert property (nmi_high_s ##0 (power_down_instruction && !power_down_mode) |=> !power_down_mode)
		else $error("power down entered with nmi high");
	oe_len_a: assert property ($fell(reset_request_pin_oe) |-> oe_cnt_r == SEQ_CYCLES)
		else $error("reset line pull has wrong length");
	pin_drive_a: assert property (reset_request_pin_oe |-> !reset_request_pin_o)
		else $error("reset line driven high");
	reset_indication_out_low_a: assert property (!core_reset_n |-> !reset_indication_out)
		else $error("reset indication high in reset");
	reset_indication_out_rise_a: assert property ($rose(reset_indication_out) |-> $past(end_of_init_instruction) || $past(end_of_init_instruction, 2))
		else $error("reset indication rose without end of init");
	reset_pin_a: assert property ((!reset_request_pin_i && oscillator_running)[*7] |-> !core_reset_n)
		else $error("reset request ignored");
	owe_low_a: assert property ((!osc_watchdog_enable_pin_i)[*5] |-> !osc_watchdog_en)
		else $error("oscillator watchdog not disabled");
	owe_high_a: assert property (osc_watchdog_enable_pin_i[*5] |-> osc_watchdog_en)
		else $error("oscillator watchdog not enabled");
endmodule

bind rbc_top rbc_assertions #(.SEQ_CYCLES(SEQ_CYCLES)) u_chk (.pclk, .presetn, .psel, .penable,
	.pready, .reset_request_pin_i, .reset_request_pin_o, .reset_request_pin_oe,
	.reset_indication_out, .nmi_pin_i, .osc_watchdog_enable_pin_i, .oscillator_running,
	.end_of_init_instruction, .power_down_instruction, .core_reset_n, .nmi_trap,
	.power_down_mode, .osc_watchdog_en);
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the reset and boot pin control block
`timescale 1ns/1ns
`default_nettype none
module tb_top import rbc_pkg::*;;
	localparam int SEQ = 8;
	localparam logic [4:0] EI = 5'h10, PD = 5'h08, SW = 5'h04, WD = 5'h02, GO = 5'h01;
	typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] q; logic e;} rbc_row_t;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdq;
	logic [7:0] port_lo, sup_len;
	logic [4:0] ev;
	logic rst_o, rst_oe, rst_ind, nmi, ea, osc_watchdog_enable_pin, osc, sup_pull;
	logic core_reset_n, nmi_trap, power_down_mode, boot_ext, boot_ldr, owe_en, irq;
	int miscompares, total_checks, n;
	wire rst_line;
	rbc_row_t rows[10] = '{
		'{1'b0, OFS_CTRL, 32'h0, 32'h0, 1'b0}, '{1'b1, OFS_CTRL, 32'h1, 32'h0, 1'b0},
		'{1'b0, OFS_CTRL, 32'h0, 32'h1, 1'b0}, '{1'b0, OFS_STATUS, 32'h0, 32'h2c3, 1'b0},
		'{1'b1, OFS_INT_STAT, 32'hf, 32'h0, 1'b0}, '{1'b0, OFS_INT_STAT, 32'h0, 32'h0, 1'b0},
		'{1'b1, OFS_INT_MASK, 32'hf, 32'h0, 1'b0}, '{1'b0, OFS_INT_MASK, 32'h0, 32'hf, 1'b0},
		'{1'b0, 12'h010, 32'h0, 32'h0, 1'b1}, '{1'b1, 12'h006, 32'h1, 32'h0, 1'b1}};

	// Open-drain reset line with pull-up
	assign rst_line = !((rst_oe && !rst_o) || sup_pull);

	rbc_top #(.SEQ_CYCLES(SEQ)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .reset_request_pin_i(rst_line),
		.reset_request_pin_o(rst_o), .reset_request_pin_oe(rst_oe),
		.reset_indication_out(rst_ind), .nmi_pin_i(nmi), .external_access_select_i(ea),
		.osc_watchdog_enable_pin_i(osc_watchdog_enable_pin), .multiplexed_bus_port_low_i(port_lo),
		.oscillator_running(osc), .end_of_init_instruction(ev[4]),
		.power_down_instruction(ev[3]), .sw_reset_req(ev[2]), .wdt_reset_req(ev[1]),
		.core_reset_n, .nmi_trap, .power_down_mode, .boot_from_external(boot_ext),
		.boot_loader_active(boot_ldr), .osc_watchdog_en(owe_en), .irq);
	rbc_sup u_sup (.pclk, .go(ev[0]), .len(sup_len), .pull(sup_pull));

	// Clock
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	// Watchdog, several times the expected run
	initial begin
		#(CLK_PERIOD_NS * 8000);
		miscompares++;
		results();
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One APB transfer; holds the request until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdq = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic pls(input logic [4:0] m);
		ev <= m;
		@(posedge pclk);
		ev <= 5'h0;
	endtask

	// Waits out one reset, counting cycles the device pulls the line
	task automatic seq(output int c);
		bit lo;
		c = 0;
		lo = 0;
		for (int i = 0; i < 300; i++) begin
			@(posedge pclk);
			c += (rst_oe === 1'b1);
			if (core_reset_n === 1'b0) lo = 1;
			if (lo && core_reset_n === 1'b1) break;
		end
		chk("reset_seq", 32'h1, 32'(lo && core_reset_n === 1'b1));
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		{psel, penable, pwrite, ev, paddr, pwdata} = '0;
		{nmi, ea, osc_watchdog_enable_pin, osc} = 4'hf;
		port_lo = 8'hef;
		sup_len = 8'h04;
		presetn = 1'b0;
		miscompares = 0;
		total_checks = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		seq(n);
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w) chk("reg_data", rows[i].q, rdq);
			chk("reg_err", 32'(rows[i].e), 32'(rerr));
		end
		chk("pins", 32'h0c, 32'({boot_ext, boot_ldr, owe_en, rst_ind, rst_oe}));
		// Refused power-down, then masking and clearing of its flag
		pls(PD);
		apb(1'b0, OFS_INT_STAT, 32'h0);
		chk("pd_refuse", 32'h8, rdq);
		chk("pd_mode", 32'h0, 32'(power_down_mode));
		chk("irq_on", 32'h1, 32'(irq));
		apb(1'b1, OFS_INT_MASK, 32'h0);
		repeat (2) @(posedge pclk);
		chk("irq_masked", 32'h0, 32'(irq));
		apb(1'b1, OFS_INT_STAT, 32'h8);
		apb(1'b1, OFS_INT_MASK, 32'hf);
		repeat (2) @(posedge pclk);
		chk("irq_clear", 32'h0, 32'(irq));
		// Falling NMI gives one trap pulse
		nmi <= 1'b0;
		n = 0;
		repeat (6) begin
			@(posedge pclk);
			n += (nmi_trap === 1'b1);
		end
		chk("nmi_trap", 32'h1, 32'(n));
		apb(1'b0, OFS_INT_STAT, 32'h0);
		chk("nmi_flag", 32'h1, rdq);
		pls(PD);
		@(posedge pclk);
		chk("pd_enter", 32'h1, 32'(power_down_mode));
		// End of init, then the enable bit is locked
		pls(EI);
		repeat (2) @(posedge pclk);
		chk("ind_high", 32'h1, 32'(rst_ind));
		apb(1'b1, OFS_CTRL, 32'h0);
		apb(1'b0, OFS_CTRL, 32'h0);
		chk("ctrl_lock", 32'h1, rdq);
		// Software reset in bidirectional mode
		nmi <= 1'b1;
		ea <= 1'b0;
		pls(SW);
		seq(n);
		chk("sw_pull", 32'(SEQ), 32'(n));
		chk("pd_clear", 32'h0, 32'(power_down_mode));
		@(posedge pclk);
		chk("boot_ext", 32'h1, 32'(boot_ext));
		chk("boot_ldr", 32'h1, 32'(boot_ldr));
		apb(1'b0, OFS_CTRL, 32'h0);
		chk("bidir_clear", 32'h0, rdq);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("bidir_cause", 32'h63, rdq & 32'h7f);
		// Short pin pulse stretched in bidirectional mode
		apb(1'b1, OFS_CTRL, 32'h1);
		pls(GO);
		seq(n);
		chk("stretch", 32'(SEQ), 32'(n));
		// Pin low with the oscillator stopped, then a long pin reset
		port_lo <= 8'hff;
		osc <= 1'b0;
		sup_len <= 8'h14;
		pls(GO);
		n = 0;
		repeat (30) begin
			@(posedge pclk);
			n += (core_reset_n !== 1'b1);
		end
		chk("osc_off", 32'h0, 32'(n));
		osc <= 1'b1;
		pls(GO);
		seq(n);
		chk("no_pull", 32'h0, 32'(n));
		@(posedge pclk);
		chk("ldr_off", 32'h0, 32'(boot_ldr));
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("hw_cause", 32'h3, rdq & 32'hf);
		// Watchdog reset without pull, then the oscillator watchdog pin
		pls(WD);
		seq(n);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("wdt_cause", 32'h8, rdq & 32'hf);
		osc_watchdog_enable_pin <= 1'b0;
		repeat (5) @(posedge pclk);
		chk("owe_off", 32'h0, 32'(owe_en));
		// Asynchronous reset in mid-run, then a fresh power-on sequence
		presetn <= 1'b0;
		@(posedge pclk);
		chk("in_reset", 32'h04, 32'({core_reset_n, rst_ind, owe_en, irq, rst_oe}));
		presetn <= 1'b1;
		seq(n);
		chk("por_pull", 32'h0, 32'(n));
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("por_cause", 32'h3, rdq & 32'hf);
		results();
	end
endmodule
`default_nettype wire
